//--- core/csf_pkg.sv
package csf_pkg;

    // Data addresses at which the flag register answers, one each in direct banks 0 and 1
    localparam logic [8:0] CSF_ADDR_BANK0 = 9'h003;
    localparam logic [8:0] CSF_ADDR_BANK1 = 9'h083;

    // Field positions inside the flag register
    localparam int unsigned CSF_BIT_C = 0;
    localparam int unsigned CSF_BIT_DC = 1;
    localparam int unsigned CSF_BIT_Z = 2;
    localparam int unsigned CSF_BIT_PWRDN = 3;
    localparam int unsigned CSF_BIT_TO = 4;
    localparam int unsigned CSF_BIT_DBANK_LO = 5;
    localparam int unsigned CSF_BIT_DBANK_HI = 6;
    localparam int unsigned CSF_BIT_IBANK = 7;

    // Reset value: both reset-cause flags set, bank bits clear.
    // Arithmetic flags are undefined after power-up; zero is chosen here.
    localparam logic [7:0] CSF_STATUS_RST = 8'h18;

    // Constants of the flag arithmetic
    localparam logic [8:0] CSF_ONE9 = 9'h001;
    localparam logic [4:0] CSF_ONE5 = 5'h01;
    localparam logic [7:0] CSF_ONE8 = 8'h01;
    localparam logic [7:0] CSF_ZERO8 = 8'h00;

    // Operation of the executing instruction, as seen by the flag logic
    typedef enum logic [3:0] {
        CSF_OP_NONE,
        CSF_OP_ADD,
        CSF_OP_SUB,
        CSF_OP_AND,
        CSF_OP_IOR,
        CSF_OP_XOR,
        CSF_OP_PASS,
        CSF_OP_CLEAR,
        CSF_OP_INC,
        CSF_OP_DEC,
        CSF_OP_COM,
        CSF_OP_ROTL,
        CSF_OP_ROTR,
        CSF_OP_SWAP
    } csf_alu_op_t;

endpackage

//--- core/csf_flag_if.sv
`timescale 1ns/1ps
`default_nettype none

interface csf_flag_if;
    import csf_pkg::*;
    // Operation and operands
    csf_alu_op_t op;
    logic [7:0] opnd_w;
    logic [7:0] opnd_f;
    logic carry_in;
    // Result and produced flags
    logic [7:0] result;
    logic c;
    logic dc;
    logic z;
    // Which flags the operation updates
    logic upd_c;
    logic upd_dc;
    logic upd_z;

    modport alu (
        input op, opnd_w, opnd_f, carry_in,
        output result, c, dc, z, upd_c, upd_dc, upd_z
    );
    modport core (
        output op, opnd_w, opnd_f, carry_in,
        input result, c, dc, z, upd_c, upd_dc, upd_z
    );
endinterface

`default_nettype wire

//--- core/csf_flag_alu.sv
`timescale 1ns/1ps
`default_nettype none

module csf_flag_alu
    import csf_pkg::*;
(
    // Operation in, result and flags out
    csf_flag_if.alu fl
);

    // Full and low-nibble sums for carry and digit carry
    logic [8:0] sum;
    logic [4:0] nib;

    // Pure combinational flag logic; no state
    always_comb begin
        sum = 9'h000;
        nib = 5'h00;
        fl.result = fl.opnd_f;
        fl.c = 1'b0;
        fl.dc = 1'b0;
        fl.upd_c = 1'b0;
        fl.upd_dc = 1'b0;
        fl.upd_z = 1'b0;
        case (fl.op)
            CSF_OP_ADD: begin
                sum = {1'b0, fl.opnd_w} + {1'b0, fl.opnd_f};
                nib = {1'b0, fl.opnd_w[3:0]} + {1'b0, fl.opnd_f[3:0]};
                fl.result = sum[7:0];
                fl.c = sum[8];
                fl.dc = nib[4];
                {fl.upd_c, fl.upd_dc, fl.upd_z} = 3'h7;
            end
            CSF_OP_SUB: begin
                // Two's complement add, so carry set means no borrow
                sum = {1'b0, fl.opnd_f} + {1'b0, ~fl.opnd_w} + CSF_ONE9;
                nib = {1'b0, fl.opnd_f[3:0]} + {1'b0, ~fl.opnd_w[3:0]} + CSF_ONE5;
                fl.result = sum[7:0];
                fl.c = sum[8];
                fl.dc = nib[4];
                {fl.upd_c, fl.upd_dc, fl.upd_z} = 3'h7;
            end
            CSF_OP_AND: begin
                fl.result = fl.opnd_w & fl.opnd_f;
                fl.upd_z = 1'b1;
            end
            CSF_OP_IOR: begin
                fl.result = fl.opnd_w | fl.opnd_f;
                fl.upd_z = 1'b1;
            end
            CSF_OP_XOR: begin
                fl.result = fl.opnd_w ^ fl.opnd_f;
                fl.upd_z = 1'b1;
            end
            CSF_OP_PASS: begin
                fl.upd_z = 1'b1;
            end
            CSF_OP_CLEAR: begin
                fl.result = CSF_ZERO8;
                fl.upd_z = 1'b1;
            end
            CSF_OP_INC: begin
                fl.result = fl.opnd_f + CSF_ONE8;
                fl.upd_z = 1'b1;
            end
            CSF_OP_DEC: begin
                fl.result = fl.opnd_f - CSF_ONE8;
                fl.upd_z = 1'b1;
            end
            CSF_OP_COM: begin
                fl.result = ~fl.opnd_f;
                fl.upd_z = 1'b1;
            end
            CSF_OP_ROTL: begin
                fl.result = {fl.opnd_f[6:0], fl.carry_in};
                fl.c = fl.opnd_f[7];
                fl.upd_c = 1'b1;
            end
            CSF_OP_ROTR: begin
                fl.result = {fl.carry_in, fl.opnd_f[7:1]};
                fl.c = fl.opnd_f[0];
                fl.upd_c = 1'b1;
            end
            CSF_OP_SWAP: begin
                // Flag-free, like move and bit set/clear
                fl.result = {fl.opnd_f[3:0], fl.opnd_f[7:4]};
            end
            default: begin
                fl.result = fl.opnd_f;
            end
        endcase
    end

    // Zero flag follows the result
    assign fl.z = (fl.result == CSF_ZERO8);

endmodule // csf_flag_alu

`default_nettype wire

//--- core/csf_status_reg.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Register writable like any data-memory register
// - Flag-updating write keeps flag logic values
// - Reset-cause flags ignore all instruction writes
// - Clear takes upper bits from the write data, sets zero flag
// - Subtraction carries act as inverted borrow outputs
// - Register mapped at both addresses, reset values
// - Indirect select bit picks banks zero/one or two/three
// - Direct select bits pick one of four 128-byte banks
// - Carry set on carry out of MSB
// - Subtraction adds two's complement of operand
// - Rotates load carry from edge bit
module csf_status_reg
    import csf_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Executing instruction
    input wire csf_alu_op_t alu_op,
    input wire logic [7:0] opnd_w,
    input wire logic [7:0] opnd_f,
    // Data-memory write
    input wire logic wr_en,
    input wire logic [8:0] wr_addr,
    input wire logic [7:0] wr_data,
    // Data-memory read
    input wire logic rd_en,
    input wire logic [8:0] rd_addr,
    // Operand address formation
    input wire logic ind_sel,
    input wire logic [6:0] file_addr,
    input wire logic [7:0] fsr_ptr,
    // Reset-cause events from watchdog and sleep logic
    input wire logic wdt_timeout,
    input wire logic wdt_clear,
    input wire logic sleep_enter,
    // Register and datapath outputs
    output logic [7:0] status_val,
    output logic [7:0] rd_data,
    output logic rd_hit,
    output logic [7:0] alu_result,
    output logic [8:0] data_addr
);

    // Whole state of the block
    typedef struct packed {
        logic [7:0] status;
        logic [7:0] rd_data;
        logic rd_hit;
        logic [7:0] result;
        logic [8:0] data_addr;
    } csf_state_t;

    csf_state_t st_q; // Registered state
    csf_state_t st_d; // Next state
    logic wr_hit; // Write aimed at the flag register
    logic rd_match; // Read aimed at the flag register

    // Flag logic
    csf_flag_if fl ();

    assign fl.op = alu_op;
    assign fl.opnd_w = opnd_w;
    assign fl.opnd_f = opnd_f;
    assign fl.carry_in = st_q.status[CSF_BIT_C];

    csf_flag_alu u_alu (
        .fl (fl)
    );

    // Both bank images decode to the same register
    assign wr_hit = wr_en && ((wr_addr == CSF_ADDR_BANK0) || (wr_addr == CSF_ADDR_BANK1));
    assign rd_match = rd_en && ((rd_addr == CSF_ADDR_BANK0) || (rd_addr == CSF_ADDR_BANK1));

    // Next-state logic
    always_comb begin
        st_d = st_q;
        // Plain data write; reset-cause bits left out on purpose
        if (wr_hit) begin
            st_d.status[CSF_BIT_IBANK] = wr_data[CSF_BIT_IBANK];
            st_d.status[CSF_BIT_DBANK_HI] = wr_data[CSF_BIT_DBANK_HI];
            st_d.status[CSF_BIT_DBANK_LO] = wr_data[CSF_BIT_DBANK_LO];
            // Any flag update locks all three flag bits against the data
            if (!(fl.upd_z || fl.upd_dc || fl.upd_c)) begin
                st_d.status[CSF_BIT_Z] = wr_data[CSF_BIT_Z];
                st_d.status[CSF_BIT_DC] = wr_data[CSF_BIT_DC];
                st_d.status[CSF_BIT_C] = wr_data[CSF_BIT_C];
            end
        end
        // Flag updates override the write, bit by bit
        if (fl.upd_z) begin
            st_d.status[CSF_BIT_Z] = fl.z;
        end
        if (fl.upd_dc) begin
            st_d.status[CSF_BIT_DC] = fl.dc;
        end
        if (fl.upd_c) begin
            st_d.status[CSF_BIT_C] = fl.c;
        end
        // Reset-cause flags move only on watchdog and sleep events
        if (wdt_timeout) begin
            st_d.status[CSF_BIT_TO] = 1'b0;
        end else if (wdt_clear) begin
            st_d.status[CSF_BIT_TO] = 1'b1;
            st_d.status[CSF_BIT_PWRDN] = 1'b1;
        end else if (sleep_enter) begin
            st_d.status[CSF_BIT_TO] = 1'b1;
            st_d.status[CSF_BIT_PWRDN] = 1'b0;
        end
        // Read returns the post-update value, so same-cycle flags win
        st_d.rd_hit = rd_match;
        if (rd_match) begin
            st_d.rd_data = st_d.status;
        end else begin
            st_d.rd_data = CSF_ZERO8;
        end
        st_d.result = fl.result;
        // Operand address; bank bits as they stand when issued
        if (ind_sel) begin
            st_d.data_addr = {st_q.status[CSF_BIT_IBANK], fsr_ptr};
        end else begin
            st_d.data_addr = {st_q.status[CSF_BIT_DBANK_HI], st_q.status[CSF_BIT_DBANK_LO],
                              file_addr};
        end
    end

    // State register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '{status: CSF_STATUS_RST, rd_data: CSF_ZERO8, rd_hit: 1'b0,
                      result: CSF_ZERO8, data_addr: 9'h000};
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register
    assign status_val = st_q.status;
    assign rd_data = st_q.rd_data;
    assign rd_hit = st_q.rd_hit;
    assign alu_result = st_q.result;
    assign data_addr = st_q.data_addr;

    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    // No reset-cause event in the cycle
    logic no_evt;
    assign no_evt = !wdt_timeout && !wdt_clear && !sleep_enter;

    sequence s_plain_write;
        wr_hit && (alu_op == CSF_OP_NONE) && no_evt;
    endsequence

    sequence s_clear_write;
        wr_hit && (alu_op == CSF_OP_CLEAR) && no_evt;
    endsequence

    AST_PLAIN_WRITE: assert property (s_plain_write |=>
        (st_q.status[7:5] == $past(wr_data[7:5])) &&
        (st_q.status[2:0] == $past(wr_data[2:0])))
        else $error("flag register write not stored");

    AST_MASKED_FLAGS: assert property ((wr_hit && fl.upd_z && fl.upd_c) |=>
        (st_q.status[CSF_BIT_Z] == $past(fl.z)) && (st_q.status[CSF_BIT_C] == $past(fl.c)))
        else $error("flag write not masked by flag update");

    AST_CAUSE_HOLD: assert property ((wr_hit && no_evt) |=>
        $stable(st_q.status[CSF_BIT_TO:CSF_BIT_PWRDN]))
        else $error("reset-cause flags changed by write");

    AST_CLEAR: assert property (s_clear_write |=>
        (st_q.status[7:5] == 3'h0) && st_q.status[CSF_BIT_Z] &&
        $stable(st_q.status[CSF_BIT_TO:CSF_BIT_PWRDN]) &&
        $stable(st_q.status[CSF_BIT_DC:CSF_BIT_C]))
        else $error("clear of flag register wrong");

    AST_SUB_BORROW: assert property ((alu_op == CSF_OP_SUB) |=>
        st_q.status[CSF_BIT_C] == ($past(opnd_f) >= $past(opnd_w)))
        else $error("subtract carry is not inverted borrow");

    AST_ADD_CARRY: assert property ((alu_op == CSF_OP_ADD) |=>
        st_q.status[CSF_BIT_C] == (({1'b0, $past(opnd_f)} + {1'b0, $past(opnd_w)}) > 9'h0ff))
        else $error("add carry wrong");

    AST_ROTATE: assert property ((alu_op == CSF_OP_ROTR) |=>
        (st_q.status[CSF_BIT_C] == $past(opnd_f[0])) &&
        (st_q.result[7] == $past(st_q.status[CSF_BIT_C])))
        else $error("rotate right carry wrong");

    AST_BANK1_ALIAS: assert property ((s_plain_write ##0 (wr_addr == CSF_ADDR_BANK1))
        |=> (status_val[CSF_BIT_DBANK_LO] == $past(wr_data[CSF_BIT_DBANK_LO])))
        else $error("upper image write not seen");

    AST_IND_BANK: assert property (ind_sel |=>
        data_addr == {$past(st_q.status[CSF_BIT_IBANK]), $past(fsr_ptr)})
        else $error("indirect bank wrong");

    AST_DIR_BANK: assert property (!ind_sel |=>
        data_addr[7] == $past(st_q.status[CSF_BIT_DBANK_LO]))
        else $error("direct bank wrong");

    AST_READ_NEW: assert property ((rd_match && wr_hit && fl.upd_z) |=>
        rd_hit && (rd_data == st_q.status))
        else $error("read does not show updated flags");

endmodule // csf_status_reg

`default_nettype wire

//--- verification/csf_core_model.sv
`timescale 1ns/1ps
`default_nettype none

// Stand-in for the instruction datapath that feeds the flag register
module csf_core_model
    import csf_pkg::*;
(
    // Executing instruction and operands
    output var csf_alu_op_t alu_op,
    output var logic [7:0] opnd_w,
    output var logic [7:0] opnd_f,
    // Data-memory write and read
    output var logic wr_en,
    output var logic [8:0] wr_addr,
    output var logic [7:0] wr_data,
    output var logic rd_en,
    output var logic [8:0] rd_addr,
    // Operand address formation
    output var logic ind_sel,
    output var logic [6:0] file_addr,
    output var logic [7:0] fsr_ptr,
    // Timeout, clear and sleep pulses
    output var logic [2:0] events
);
    // Quiet bus at time zero
    initial begin
        alu_op = CSF_OP_NONE;
        {opnd_w, opnd_f, wr_en, wr_addr, wr_data, rd_en, rd_addr} = '0;
        {ind_sel, file_addr, fsr_ptr, events} = '0;
    end

    // Called just after an edge; one instruction holds for the whole cycle
    task automatic drive(input csf_alu_op_t op, input logic [7:0] w, input logic [7:0] f,
        input logic wr, input logic [8:0] wa, input logic [7:0] wd, input logic [8:0] ra,
        input logic ind, input logic [6:0] fa, input logic [7:0] fp, input logic [2:0] ev);
        alu_op <= op;
        opnd_w <= w;
        opnd_f <= f;
        wr_en <= wr;
        wr_addr <= wa;
        wr_data <= wd;
        rd_en <= ra != 9'h000; // Address zero means no read
        rd_addr <= ra;
        ind_sel <= ind;
        file_addr <= fa;
        fsr_ptr <= fp;
        events <= ev; // Pulses last exactly one cycle
    endtask
endmodule // csf_core_model

`default_nettype wire

//--- verification/test_cpu_status_flag_register.sv
`timescale 1ns/1ps
`default_nettype none

// Self-checking bench: driver notes expectations, monitor compares them
module test_cpu_status_flag_register;
    import csf_pkg::*;

    // Expected value and the bits of it that are defined
    typedef struct packed {
        logic [33:0] v;
        logic [33:0] m;
    } csf_note_t;

    logic sys_clk = 1'b0; // 10 MHz bench clock
    logic rst_n = 1'b0; // Held low for the first 8 cycles
    csf_alu_op_t alu_op, op;
    logic [7:0] opnd_w, opnd_f, wr_data, fsr_ptr, w, f;
    logic wr_en, rd_en, ind_sel, rd_hit;
    logic [8:0] wr_addr, rd_addr, data_addr;
    logic [6:0] file_addr;
    logic [2:0] events;
    logic [7:0] status_val, rd_data, alu_result;
    logic [7:0] cur = CSF_STATUS_RST; // Reference copy of the register
    logic issued = 1'b0; // An instruction was driven this cycle
    logic issued_q = 1'b0; // Its result is visible now
    logic [31:0] seed;
    logic [8:0] addrs [4] = '{9'h003, 9'h083, 9'h004, 9'h080};
    csf_note_t notes[$];
    csf_note_t mon_n;
    int fails = 0;
    int cmp_count = 0;

    always #50 sys_clk = ~sys_clk;

    csf_core_model u_core (.alu_op(alu_op), .opnd_w(opnd_w), .opnd_f(opnd_f), .wr_en(wr_en),
        .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr),
        .ind_sel(ind_sel), .file_addr(file_addr), .fsr_ptr(fsr_ptr), .events(events));

    csf_status_reg dut (.sys_clk(sys_clk), .rst_n(rst_n), .alu_op(alu_op), .opnd_w(opnd_w),
        .opnd_f(opnd_f), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en),
        .rd_addr(rd_addr), .ind_sel(ind_sel), .file_addr(file_addr), .fsr_ptr(fsr_ptr),
        .wdt_timeout(events[0]), .wdt_clear(events[1]), .sleep_enter(events[2]),
        .status_val(status_val), .rd_data(rd_data), .rd_hit(rd_hit),
        .alu_result(alu_result), .data_addr(data_addr));

    // Galois-free shift register, fixed seed for repeatable runs
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Compare and count
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Work out the next register value, then issue the instruction
    task automatic step(input csf_alu_op_t o, input logic [7:0] wv, input logic [7:0] fv,
        input logic wr, input logic [8:0] wa, input logic [7:0] wd, input logic [8:0] ra,
        input logic ind, input logic [6:0] fa, input logic [7:0] fp, input logic [2:0] ev);
        logic [8:0] r;
        logic [7:0] nx;
        logic [2:0] fl;
        logic [2:0] up;
        logic hit;
        csf_note_t n;
        nx = cur;
        case (o)
            CSF_OP_ADD: r = {1'b0, fv} + {1'b0, wv};
            CSF_OP_SUB: r = {1'b0, fv} + {1'b0, ~wv} + 9'h001; // Borrow shows as carry low
            CSF_OP_AND: r = {1'b0, fv & wv};
            CSF_OP_IOR: r = {1'b0, fv | wv};
            CSF_OP_XOR: r = {1'b0, fv ^ wv};
            CSF_OP_CLEAR: r = 9'h000;
            CSF_OP_INC: r = {1'b0, fv + 8'h01};
            CSF_OP_DEC: r = {1'b0, fv - 8'h01};
            CSF_OP_COM: r = {1'b0, ~fv};
            CSF_OP_ROTL: r = {fv, cur[0]}; // Bit 8 is the bit shifted out
            CSF_OP_ROTR: r = {fv[0], cur[0], fv[7:1]};
            CSF_OP_SWAP: r = {1'b0, fv[3:0], fv[7:4]};
            default: r = {1'b0, fv};
        endcase
        up = 3'h4; // Default: logic ops, pass, clear, inc, dec and complement touch zero only
        if (o inside {CSF_OP_ADD, CSF_OP_SUB}) up = 3'h7;
        if (o inside {CSF_OP_ROTL, CSF_OP_ROTR}) up = 3'h1;
        if (o inside {CSF_OP_NONE, CSF_OP_SWAP}) up = 3'h0;
        fl[2] = r[7:0] == 8'h00;
        fl[1] = (o == CSF_OP_SUB) ? (fv[3:0] >= wv[3:0])
            : (({1'b0, fv[3:0]} + {1'b0, wv[3:0]}) > 5'h0f);
        fl[0] = r[8];
        if (wr && (wa == CSF_ADDR_BANK0 || wa == CSF_ADDR_BANK1)) begin
            nx[7:5] = wd[7:5]; // Cause flags never written
            if (up == 3'h0) nx[2:0] = wd[2:0]; // Any flag update blocks all three
        end
        nx[2:0] = (up & fl) | (~up & nx[2:0]); // Flag logic wins over the data
        if (ev[0]) nx[4] = 1'b0;
        else if (ev[1]) nx[4:3] = 2'b11;
        else if (ev[2]) nx[4:3] = 2'b10;
        hit = ra == CSF_ADDR_BANK0 || ra == CSF_ADDR_BANK1;
        n.v = {nx, hit, hit ? nx : 8'h00, r[7:0], ind ? {cur[7], fp} : {cur[6], cur[5], fa}};
        // Result of a no-op is not defined
        n.m = {17'h1ffff, (o == CSF_OP_NONE) ? 8'h00 : 8'hff, 9'h1ff};
        cur = nx;
        @(posedge sys_clk);
        u_core.drive(o, wv, fv, wr, wa, wd, ra, ind, fa, fp, ev);
        issued <= 1'b1;
        notes.push_back(n);
    endtask

    // Bus back to quiet, nothing more expected
    task automatic idle();
        @(posedge sys_clk);
        u_core.drive(CSF_OP_NONE, 8'h00, 8'h00, 1'b0, 9'h000, 8'h00, 9'h000, 1'b0, 7'h00,
            8'h00, 3'h0);
        issued <= 1'b0;
    endtask

    // Monitor: oldest note against what the outputs show
    always @(posedge sys_clk) issued_q <= issued;
    always @(negedge sys_clk) begin
        if (issued_q && notes.size() > 0) begin
            mon_n = notes.pop_front();
            check({status_val, rd_hit, rd_data, alu_result, data_addr} & mon_n.m,
                mon_n.v & mon_n.m);
        end
    end

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Watchdog: whole run needs well under 1000 cycles
    initial begin
        repeat (3000) @(posedge sys_clk);
        fails++;
        results();
    end

    // Main sequence
    initial begin
        seed = 32'hcb2f;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        step(CSF_OP_NONE, 8'h00, 8'h00, 1'b0, 9'h000, 8'h00, 9'h003, 1'b0, 7'h00, 8'h00, 3'h0);
        // Flag-free write at the upper mirror, then every op writing the register
        step(CSF_OP_NONE, 8'h00, 8'h00, 1'b1, 9'h083, 8'h27, 9'h003, 1'b0, 7'h11, 8'h00, 3'h0);
        for (int i = 0; i < 14; i++) begin
            // A clear always carries zero data into the register
            step(csf_alu_op_t'(i), 8'h8c, 8'h8c, 1'b1, 9'h003,
                (i[0] && (csf_alu_op_t'(i) != CSF_OP_CLEAR)) ? 8'hff : 8'h00, 9'h083,
                1'b0, 7'h7f, 8'h00, 3'h0);
        end
        step(CSF_OP_CLEAR, 8'h00, 8'h00, 1'b1, 9'h003, 8'h00, 9'h003, 1'b0, 7'h00, 8'h00, 3'h0);
        step(CSF_OP_SUB, 8'h03, 8'h05, 1'b0, 9'h000, 8'h00, 9'h003, 1'b0, 7'h00, 8'h00, 3'h0);
        step(CSF_OP_SUB, 8'h05, 8'h03, 1'b0, 9'h000, 8'h00, 9'h003, 1'b0, 7'h00, 8'h00, 3'h0);
        // Bank bits set on purpose to see both address modes move
        step(CSF_OP_NONE, 8'h00, 8'h00, 1'b1, 9'h003, 8'he0, 9'h004, 1'b0, 7'h00, 8'h00, 3'h0);
        step(CSF_OP_NONE, 8'h00, 8'h00, 1'b0, 9'h000, 8'h00, 9'h003, 1'b1, 7'h00, 8'h5a, 3'h0);
        step(CSF_OP_NONE, 8'h00, 8'h00, 1'b0, 9'h000, 8'h00, 9'h003, 1'b0, 7'h2a, 8'h00, 3'h0);
        // Cause-flag events alone and all at once, with a write trying to set them
        for (int i = 1; i < 8; i++) begin
            step(CSF_OP_NONE, 8'h00, 8'h00, 1'b1, 9'h083, 8'h18, 9'h083, 1'b0, 7'h00, 8'h00,
                i[2:0]);
        end
        for (int k = 0; k < 150; k++) begin
            seed = lfsr(lfsr(seed));
            op = (seed[3:0] > 4'hd) ? CSF_OP_NONE : csf_alu_op_t'(seed[3:0]);
            w = seed[11:4];
            f = (op == CSF_OP_PASS) ? seed[11:4] : seed[19:12];
            // Ordinary traffic keeps the two upper bank bits (7 and 6) clear
            step(op, w, f, seed[20], addrs[seed[22:21]],
                (op == CSF_OP_CLEAR) ? 8'h00 : (seed[31:24] & 8'h3f),
                addrs[seed[24:23]], seed[25], seed[31:25], seed[30:23],
                (seed[29:27] == 3'h0) ? seed[2:0] : 3'h0);
        end
        // Second reset in mid-run brings the reset value back
        idle();
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        cur = CSF_STATUS_RST;
        step(CSF_OP_NONE, 8'h00, 8'h00, 1'b0, 9'h000, 8'h00, 9'h083, 1'b0, 7'h00, 8'h00, 3'h0);
        idle();
        repeat (3) @(posedge sys_clk);
        results();
    end
endmodule // test_cpu_status_flag_register

`default_nettype wire
